// file: smn_pkg.sv
// Constants shared by the switch-port MAC host and its FIFO
`default_nettype none
package smn_pkg;
	localparam int NIB_W = 4;
	localparam int FIFO_DEPTH = 32;
	// FIFO word layout: {last, error, nibble}
	localparam int WORD_W = NIB_W + 2;
	localparam int W_ERR = NIB_W;
	localparam int W_LAST = NIB_W + 1;
	localparam int SER_BIT = 0;
	localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
	localparam logic [WORD_W-1:0] WORD_ZERO = 6'h00;
	localparam logic [1:0] SYNC_ZERO = 2'h0;
	localparam logic [2*NIB_W-1:0] DSYNC_ZERO = 8'h00;
	typedef enum logic [1:0] {SMN_TX_IDLE, SMN_TX_SEND, SMN_TX_STOP} smn_tx_state_t;
endpackage : smn_pkg
`default_nettype wire

// file: smn_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`default_nettype none
module smn_fifo #(
	parameter int WIDTH = 6,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic             ce_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	import smn_pkg::*;
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wr_ptr;
		logic [AW:0]                 rd_ptr;
	} smn_fifo_state_t;
	smn_fifo_state_t s;
	smn_fifo_state_t next_s;
	logic full;
	logic empty;
	always_comb
	begin
		// Extra pointer bit tells full from empty
		empty = (s.wr_ptr == s.rd_ptr);
		full = (s.wr_ptr[AW-1:0] == s.rd_ptr[AW-1:0]) && (s.wr_ptr[AW] != s.rd_ptr[AW]);
		in_ready_out = !full && ce_in;
		out_valid_out = !empty && ce_in;
		out_data_out = s.mem[s.rd_ptr[AW-1:0]];
		next_s = s;
		if (in_valid_in && in_ready_out)
		begin
			next_s.mem[s.wr_ptr[AW-1:0]] = in_data_in;
			next_s.wr_ptr = s.wr_ptr + 1'b1;
		end
		if (out_valid_out && out_ready_in)
			next_s.rd_ptr = s.rd_ptr + 1'b1;
	end
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			s.mem <= '0;
			s.wr_ptr <= '0;
			s.rd_ptr <= '0;
		end
		else if (ce_in)
			s <= next_s;
	end
endmodule // smn_fifo
`default_nettype wire

// file: smn_host.sv
// External MAC end of the switch-MAC nibble/serial link (switch in PHY mode)
//
// Behaviour
// - Nibble mode moves four unencoded bits per clock each way.
// - Sender qualifies nibbles with enable and error; receiver gets valid and error.
// - External MAC facing switch PHY mode keeps its receive-error input low.
// - External PHY facing switch MAC mode keeps its transmit-error input low.
// - MAC mode: switch sends on receive-named pins, takes frames on transmit pins.
// - PHY mode: MAC drives transmit enable, error, data; switch drives rest and clocks.
// - Two switches link back to back, PHY mode to MAC mode, crossed mapping.
// - Serial mode moves one unencoded bit per clock each way.
// - Serial mode uses data bit 0; carrier on receive valid pin; collision pin.
// - Serial transmitter asserts enable while data valid; receiver marks valid data.
`default_nettype none
module smn_host (
	input  wire logic                        clk_in,
	input  wire logic                        rst_in,
	input  wire logic                        ce_in,
	input  wire logic                        serial_mode_in,
	input  wire logic                        tx_valid_in,
	output logic                             tx_ready_out,
	input  wire logic [smn_pkg::NIB_W-1:0]   tx_data_in,
	input  wire logic                        tx_error_in,
	input  wire logic                        tx_last_in,
	output logic                             rx_valid_out,
	output logic      [smn_pkg::NIB_W-1:0]   rx_data_out,
	output logic                             rx_end_out,
	output logic                             carrier_out,
	output logic                             collision_out,
	output logic                             tx_busy_out,
	input  wire logic                        swif_tx_clock_in,
	output logic                             swif_tx_enable_out,
	output logic                             swif_tx_error_out,
	output logic      [smn_pkg::NIB_W-1:0]   swif_tx_nibble_out,
	input  wire logic                        swif_rx_clock_in,
	input  wire logic                        swif_rx_valid_in,
	input  wire logic [smn_pkg::NIB_W-1:0]   swif_rx_nibble_in,
	input  wire logic                        swif_collision_in,
	input  wire logic                        swif_carrier_sense_in
);
	import smn_pkg::*;

	typedef struct packed {
		logic [1:0]          txc_sync;
		logic                txc_prev;
		logic [1:0]          rxc_sync;
		logic                rxc_prev;
		logic [1:0]          rxdv_sync;
		logic [2*NIB_W-1:0]  rxd_sync;
		logic [1:0]          col_sync;
		logic [1:0]          crs_sync;
		smn_tx_state_t       tx_state;
		logic                tx_en;
		logic                tx_err;
		logic [NIB_W-1:0]    tx_nib;
		logic                rx_in_frame;
		logic                rx_valid;
		logic [NIB_W-1:0]    rx_data;
		logic                rx_end;
		logic                carrier;
		logic                collision;
	} smn_host_state_t;

	smn_host_state_t s;
	smn_host_state_t next_s;

	logic              fifo_valid;
	logic              fifo_pop;
	logic [WORD_W-1:0] fifo_word;
	logic              txc_fall;
	logic              rxc_fall;
	logic              rx_qual;
	logic [NIB_W-1:0]  rx_sample;

	// Outgoing words wait here so the user can run ahead of the slow link clock
	smn_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.ce_in         (ce_in),
		.in_valid_in   (tx_valid_in),
		.in_ready_out  (tx_ready_out),
		.in_data_in    ({tx_last_in, tx_error_in, tx_data_in}),
		.out_valid_out (fifo_valid),
		.out_ready_in  (fifo_pop),
		.out_data_out  (fifo_word)
	);

	always_comb
	begin
		next_s = s;
		// Pins are asynchronous to clk_in: two flops before any use
		next_s.txc_sync = {s.txc_sync[0], swif_tx_clock_in};
		next_s.rxc_sync = {s.rxc_sync[0], swif_rx_clock_in};
		next_s.rxdv_sync = {s.rxdv_sync[0], swif_rx_valid_in};
		next_s.rxd_sync = {s.rxd_sync[NIB_W-1:0], swif_rx_nibble_in};
		next_s.col_sync = {s.col_sync[0], swif_collision_in};
		next_s.crs_sync = {s.crs_sync[0], swif_carrier_sense_in};
		next_s.txc_prev = s.txc_sync[1];
		next_s.rxc_prev = s.rxc_sync[1];
		// Falling edges: mid-cell, far from where the switch launches or samples
		txc_fall = s.txc_prev && !s.txc_sync[1];
		rxc_fall = s.rxc_prev && !s.rxc_sync[1];
		rx_qual = s.rxdv_sync[1];
		rx_sample = s.rxd_sync[2*NIB_W-1:NIB_W];
		fifo_pop = 1'b0;
		next_s.rx_valid = 1'b0;
		next_s.rx_end = 1'b0;

		// Serial mode: carrier comes on the receive-valid pin
		next_s.carrier = serial_mode_in ? rx_qual : s.crs_sync[1];
		next_s.collision = s.col_sync[1];

		// Receive: data taken only while the switch marks it valid
		// No receive-error pin: the switch never drives one in PHY mode
		if (rxc_fall)
		begin
			if (rx_qual)
			begin
				next_s.rx_in_frame = 1'b1;
				next_s.rx_valid = 1'b1;
				if (serial_mode_in)
					next_s.rx_data = {{(NIB_W-1){1'b0}}, rx_sample[SER_BIT]};
				else
					next_s.rx_data = rx_sample;
			end
			else if (s.rx_in_frame)
			begin
				next_s.rx_in_frame = 1'b0;
				next_s.rx_end = 1'b1;
			end
		end

		// Transmit: one word per link clock, launched on the falling edge
		if (txc_fall)
		begin
			case (s.tx_state)
				SMN_TX_IDLE:
				begin
					next_s.tx_en = 1'b0;
					next_s.tx_err = 1'b0;
					next_s.tx_nib = NIB_ZERO;
					if (fifo_valid)
					begin
						fifo_pop = 1'b1;
						next_s.tx_en = 1'b1;
						next_s.tx_err = fifo_word[W_ERR];
						next_s.tx_nib = serial_mode_in
							? {{(NIB_W-1){1'b0}}, fifo_word[SER_BIT]}
							: fifo_word[NIB_W-1:0];
						next_s.tx_state = fifo_word[W_LAST] ? SMN_TX_STOP : SMN_TX_SEND;
					end
				end
				SMN_TX_SEND:
				begin
					if (fifo_valid)
					begin
						fifo_pop = 1'b1;
						next_s.tx_err = fifo_word[W_ERR];
						next_s.tx_nib = serial_mode_in
							? {{(NIB_W-1){1'b0}}, fifo_word[SER_BIT]}
							: fifo_word[NIB_W-1:0];
						if (fifo_word[W_LAST])
							next_s.tx_state = SMN_TX_STOP;
					end
					else
					begin
						// Underrun cannot be hidden: flag it and close the frame
						next_s.tx_err = 1'b1;
						next_s.tx_nib = NIB_ZERO;
						next_s.tx_state = SMN_TX_STOP;
					end
				end
				SMN_TX_STOP:
				begin
					next_s.tx_en = 1'b0;
					next_s.tx_err = 1'b0;
					next_s.tx_nib = NIB_ZERO;
					next_s.tx_state = SMN_TX_IDLE;
				end
				default:
				begin
					next_s.tx_en = 1'b0;
					next_s.tx_err = 1'b0;
					next_s.tx_nib = NIB_ZERO;
					next_s.tx_state = SMN_TX_IDLE;
				end
			endcase
		end

		// MAC end of a PHY-mode port; a MAC-mode switch needs the crossed pins
		// Same pin groups would serve the PHY-only transceiver port
		swif_tx_enable_out = s.tx_en;
		swif_tx_error_out = s.tx_err;
		swif_tx_nibble_out = s.tx_nib;
		rx_valid_out = s.rx_valid;
		rx_data_out = s.rx_data;
		rx_end_out = s.rx_end;
		carrier_out = s.carrier;
		collision_out = s.collision;
		tx_busy_out = (s.tx_state != SMN_TX_IDLE);
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			s.txc_sync <= SYNC_ZERO;
			s.txc_prev <= 1'b0;
			s.rxc_sync <= SYNC_ZERO;
			s.rxc_prev <= 1'b0;
			s.rxdv_sync <= SYNC_ZERO;
			s.rxd_sync <= DSYNC_ZERO;
			s.col_sync <= SYNC_ZERO;
			s.crs_sync <= SYNC_ZERO;
			s.tx_state <= SMN_TX_IDLE;
			s.tx_en <= 1'b0;
			s.tx_err <= 1'b0;
			s.tx_nib <= NIB_ZERO;
			s.rx_in_frame <= 1'b0;
			s.rx_valid <= 1'b0;
			s.rx_data <= NIB_ZERO;
			s.rx_end <= 1'b0;
			s.carrier <= 1'b0;
			s.collision <= 1'b0;
		end
		else if (ce_in)
			s <= next_s;
	end
endmodule // smn_host
`default_nettype wire

// file: smn_host_monitor.sv
// Port checks for the switch-MAC host
`default_nettype none
module smn_host_monitor (
	input wire logic                      clk_in,
	input wire logic                      rst_in,
	input wire logic                      ce_in,
	input wire logic                      serial_mode_in,
	input wire logic                      rx_valid_out,
	input wire logic [smn_pkg::NIB_W-1:0] rx_data_out,
	input wire logic                      rx_end_out,
	input wire logic                      carrier_out,
	input wire logic                      collision_out,
	input wire logic                      tx_busy_out,
	input wire logic                      swif_tx_clock_in,
	input wire logic                      swif_tx_enable_out,
	input wire logic                      swif_tx_error_out,
	input wire logic [smn_pkg::NIB_W-1:0] swif_tx_nibble_out,
	input wire logic                      swif_rx_clock_in,
	input wire logic                      swif_rx_valid_in,
	input wire logic [smn_pkg::NIB_W-1:0] swif_rx_nibble_in,
	input wire logic                      swif_collision_in,
	input wire logic                      swif_carrier_sense_in
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_in); endclocking
	// Frozen cycles hold pulses high, so they are not judged
	default disable iff (rst_in || !ce_in);
	property p_idle; !tx_busy_out |-> !swif_tx_enable_out; endproperty
	a_idle: assert property (p_idle) else $error("enable while idle");
	property p_err; swif_tx_error_out |-> swif_tx_enable_out; endproperty
	a_err: assert property (p_err) else $error("error outside frame");
	property p_cell; $changed({swif_tx_enable_out, swif_tx_error_out, swif_tx_nibble_out})
		|-> !$past(swif_tx_clock_in, 2) && $past(swif_tx_clock_in, 7); endproperty
	a_cell: assert property (p_cell) else $error("tx pins moved off fall");
	property p_pulse; rx_valid_out |=> !rx_valid_out; endproperty
	a_pulse: assert property (p_pulse) else $error("rx valid too long");
	property p_rxat; rx_valid_out |-> $past(swif_rx_valid_in, 4)
		&& !$past(swif_rx_clock_in, 2) && $past(swif_rx_clock_in, 7); endproperty
	a_rxat: assert property (p_rxat) else $error("rx word without cause");
	property p_rxd; rx_valid_out
		|-> rx_data_out == ($past(swif_rx_nibble_in, 4) & (serial_mode_in ? 4'h1 : 4'hF));
	endproperty
	a_rxd: assert property (p_rxd) else $error("rx data wrong");
	property p_end; rx_end_out |-> !$past(swif_rx_valid_in, 4) ##1 !rx_end_out; endproperty
	a_end: assert property (p_end) else $error("frame end wrong");
	property p_col; $rose(swif_collision_in) |-> ##[1:5] collision_out; endproperty
	a_col: assert property (p_col) else $error("collision lost");
	property p_crs; $rose(serial_mode_in ? swif_rx_valid_in : swif_carrier_sense_in)
		|-> ##[1:5] carrier_out; endproperty
	a_crs: assert property (p_crs) else $error("carrier lost");
endmodule // smn_host_monitor
bind smn_host smn_host_monitor i_mon (.*);
`default_nettype wire

// file: smn_switch_model.sv
// Switch port in PHY mode facing the host; no receive-error pin
`default_nettype none
module smn_switch_model (
	input  wire logic                      serial_mode_in,
	output logic                           swif_tx_clock_out,
	input  wire logic                      swif_tx_enable_in,
	input  wire logic                      swif_tx_error_in,
	input  wire logic [smn_pkg::NIB_W-1:0] swif_tx_nibble_in,
	output logic                           swif_rx_clock_out,
	output logic                           swif_rx_valid_out,
	output logic      [smn_pkg::NIB_W-1:0] swif_rx_nibble_out,
	output logic                           swif_collision_out,
	output logic                           swif_carrier_sense_out
);
	timeunit 1ns;
	timeprecision 100ps;
	import smn_pkg::*;
	logic [4:0] rx_q[$];
	logic [4:0] cap_q[$];
	logic       col_req = 1'b0;
	initial swif_tx_clock_out = 1'b0;
	initial swif_rx_clock_out = 1'b0;
	initial swif_rx_valid_out = 1'b0;
	initial swif_rx_nibble_out = NIB_ZERO;
	// Both link clocks come from the switch, receive edges 37 ns after transmit edges
	always #80 swif_tx_clock_out = ~swif_tx_clock_out;
	always #80 swif_rx_clock_out <= #37 ~swif_rx_clock_out;
	// Serial mode looks at bit 0 only
	always @(posedge swif_tx_clock_out)
		if (swif_tx_enable_in)
			cap_q.push_back({swif_tx_error_in, swif_tx_nibble_in
				& (serial_mode_in ? 4'h1 : 4'hF)});
	// Idle data shows the inverse, never a stale copy
	always @(posedge swif_rx_clock_out)
		if (rx_q.size() > 0)
			{swif_rx_valid_out, swif_rx_nibble_out} <= rx_q.pop_front();
		else
			{swif_rx_valid_out, swif_rx_nibble_out} <= {1'b0, ~swif_rx_nibble_out};
	assign swif_carrier_sense_out = swif_tx_enable_in | swif_rx_valid_out;
	assign swif_collision_out = col_req & swif_tx_enable_in;
endmodule // smn_switch_model
`default_nettype wire

// file: test_fifth_port_mii_sni_interface.sv
// Self-checking bench for the switch-MAC host
`default_nettype none
module test_fifth_port_mii_sni_interface;
	timeunit 1ns;
	timeprecision 100ps;
	import smn_pkg::*;
	logic       clk_in = 1'b0;
	logic       rst_in = 1'b1;
	logic       ce_in = 1'b1;
	logic       ser = 1'b0;
	logic       tx_valid = 1'b0;
	logic [3:0] tx_data = 4'h0;
	logic       tx_err = 1'b0;
	logic       tx_last = 1'b0;
	logic       tx_ready, rx_valid, rx_end, carrier, collision, busy;
	logic [3:0] rx_data, nib, rn;
	logic       txc, en, er, rxc, rv, col, crs;
	logic       full_seen = 1'b0;
	logic       col_seen = 1'b0;
	logic       crs_seen = 1'b0;
	logic [4:0] exp_tx[$];
	logic [3:0] exp_rx[$];
	int         n_errors = 0;
	int         check_count = 0;
	int         n_end = 0;
	always #2.5 clk_in = ~clk_in;
	smn_host i_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .serial_mode_in(ser),
		.tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .tx_data_in(tx_data),
		.tx_error_in(tx_err), .tx_last_in(tx_last), .rx_valid_out(rx_valid),
		.rx_data_out(rx_data), .rx_end_out(rx_end), .carrier_out(carrier),
		.collision_out(collision), .tx_busy_out(busy), .swif_tx_clock_in(txc),
		.swif_tx_enable_out(en), .swif_tx_error_out(er), .swif_tx_nibble_out(nib),
		.swif_rx_clock_in(rxc), .swif_rx_valid_in(rv), .swif_rx_nibble_in(rn),
		.swif_collision_in(col), .swif_carrier_sense_in(crs));
	smn_switch_model i_sw (.serial_mode_in(ser), .swif_tx_clock_out(txc),
		.swif_tx_enable_in(en), .swif_tx_error_in(er), .swif_tx_nibble_in(nib),
		.swif_rx_clock_out(rxc), .swif_rx_valid_out(rv), .swif_rx_nibble_out(rn),
		.swif_collision_out(col), .swif_carrier_sense_out(crs));
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (exp !== got)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bound(input int k);
		if (k >= 20000)
		begin
			n_errors++;
			$display("wrong value wait expected done seen timeout");
			summarize();
		end
	endtask
	always @(posedge clk_in)
	begin
		full_seen <= full_seen | (tx_valid & ~tx_ready);
		col_seen <= col_seen | collision;
		crs_seen <= crs_seen | carrier;
		if (rx_valid)
			chk("rx word", 8'(exp_rx.pop_front()), 8'(rx_data));
		if (rx_end)
			n_end++;
	end
	task automatic put(input logic [4:0] w, input logic l);
		int k;
		k = 0;
		{tx_err, tx_data} <= w;
		tx_last <= l;
		tx_valid <= 1'b1;
		#1;
		// Full FIFO refuses; the word is held until taken
		while (!tx_ready && k < 20000)
		begin
			@(posedge clk_in);
			#1;
			k++;
		end
		bound(k);
		@(posedge clk_in);
	endtask
	task automatic send_frame(input string name, input int n, input logic l);
		logic [4:0] w;
		int k;
		k = 0;
		@(posedge clk_in);
		for (int i = 0; i < n; i++)
		begin
			w = 5'($urandom);
			w[4] = !ser && ($urandom % 8 == 0);
			exp_tx.push_back({w[4], w[3:0] & (ser ? 4'h1 : 4'hF)});
			put(w, l && i == n - 1);
		end
		if (!l)
			exp_tx.push_back(5'h10);
		tx_valid <= 1'b0;
		while ((i_sw.cap_q.size() < exp_tx.size() || busy) && k < 20000)
		begin
			@(posedge clk_in);
			k++;
		end
		bound(k);
		chk("cells", 8'(exp_tx.size()), 8'(i_sw.cap_q.size()));
		foreach (exp_tx[i]) chk("cell", 8'(exp_tx[i]), 8'(i_sw.cap_q[i]));
		exp_tx.delete();
		i_sw.cap_q.delete();
		$display("end %s", name);
	endtask
	task automatic rx_frame(input string name, input int n);
		logic [3:0] r;
		int k;
		int e0;
		k = 0;
		e0 = n_end;
		for (int i = 0; i < n; i++)
		begin
			r = 4'($urandom);
			i_sw.rx_q.push_back({1'b1, r});
			exp_rx.push_back(ser ? {3'h0, r[0]} : r);
		end
		while ((exp_rx.size() > 0 || n_end == e0) && k < 20000)
		begin
			@(posedge clk_in);
			k++;
		end
		bound(k);
		chk("frame ends", 8'h01, 8'(n_end - e0));
		$display("end %s", name);
	endtask
	initial
	begin
		void'($urandom(32'h4C18));
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		#1;
		chk("ready", 8'h01, 8'(tx_ready));
		chk("tx pins", 8'h00, 8'({en, er, nib}));
		chk("busy", 8'h00, 8'(busy));
		i_sw.col_req = 1'b1;
		send_frame("nibble tx", 40, 1'b1);
		i_sw.col_req = 1'b0;
		chk("refused", 8'h01, 8'(full_seen));
		chk("collision", 8'h01, 8'(col_seen));
		chk("carrier", 8'h01, 8'(crs_seen));
		send_frame("underrun", 2, 1'b0);
		rx_frame("nibble rx", 12);
		ce_in <= 1'b0;
		@(posedge clk_in);
		#1;
		chk("held", 8'h00, 8'(tx_ready));
		@(posedge clk_in);
		ce_in <= 1'b1;
		ser <= 1'b1;
		repeat (80) @(posedge clk_in);
		send_frame("serial tx", 16, 1'b1);
		rx_frame("serial rx", 16);
		summarize();
	end
endmodule // test_fifth_port_mii_sni_interface
`default_nettype wire
